// ### rtl/rae_irq.v
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "rae_defs.vh"

module rae_irq #(
  parameter [`RAE_CNT_W-1:0]    AIS_CYC = `RAE_AIS_MS * `RAE_CLK_KHZ,
  parameter [`RAE_CNT_W-1:0]    YEL_CYC = `RAE_YEL_MS * `RAE_CLK_KHZ
) (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rstn,
  // Register port
  input  wire [`RAE_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // Line side conditions
  input  wire                   frame_bit_tick,
  input  wire                   frame_bit_err,
  input  wire                   frame_realigned,
  input  wire                   all_ones_raw,
  input  wire                   remote_alarm_raw,
  input  wire                   loss_of_signal,
  input  wire                   line_code_error,
  // Interrupt and state
  output wire                   alarm_irq,
  output wire                   frame_loss_state
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]                    frm_cfg_reg;
  reg  [3:0]                    irq_enable_reg;
  reg                           alarm_block_irq_enable_reg;
  reg  [3:0]                    status_reg;
  reg  [3:0]                    status_next;
  reg  [7:0]                    rdata_next;
  reg  [7:0]                    frm_cfg_next;
  reg  [3:0]                    irq_enable_next;
  reg                           alarm_block_irq_enable_next;
  reg                           alarm_irq_reg;
  wire [3:0]                    src_irq_next;

  wire [3:0]                    frame_error_tolerance;
  wire [3:0]                    frame_error_window;
  wire                          line_code_error_irq_enable;
  wire                          frame_loss_change_irq_enable;

  assign frame_error_tolerance        = frm_cfg_reg[`RAE_TOL_HI:`RAE_TOL_LO];
  assign frame_error_window           = frm_cfg_reg[`RAE_WIN_HI:`RAE_WIN_LO];
  assign line_code_error_irq_enable   = irq_enable_reg[`RAE_BIT_LCV];
  assign frame_loss_change_irq_enable = irq_enable_reg[`RAE_BIT_OOF_CHG];

  function hit;
    input [`RAE_ADDR_W-1:0] a;
    input [`RAE_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function edge_seen;
    input now_v;
    input old_v;
    begin
      edge_seen = now_v ^ old_v;
    end
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire                          cfg_sel;
  wire                          blk_sel;
  wire                          sts_sel;
  wire                          ena_sel;

  assign cfg_sel = hit(reg_addr, `RAE_OFS_FRM_CFG);
  assign blk_sel = hit(reg_addr, `RAE_OFS_BLK_EN);
  assign sts_sel = hit(reg_addr, `RAE_OFS_STATUS);
  assign ena_sel = hit(reg_addr, `RAE_OFS_ENABLE);

  // ----------------------------------------------------------------
  // Frame-loss detector
  // ----------------------------------------------------------------
  localparam [1:0]              FL_ALIGNED = 2'b01;
  localparam [1:0]              FL_LOST    = 2'b10;

  reg  [1:0]                    fl_state_reg;
  reg  [1:0]                    fl_state_next;
  reg  [3:0]                    win_cnt_reg;
  reg  [3:0]                    win_cnt_next;
  reg  [3:0]                    err_cnt_reg;
  reg  [3:0]                    err_cnt_next;
  wire                          oof_state;
  wire                          err_hit;
  wire                          err_limit;
  wire                          win_end;

  // One-hot: the lost bit is the defect state
  assign oof_state        = fl_state_reg[1];
  assign frame_loss_state = oof_state;
  assign err_hit          = frame_bit_tick && frame_bit_err;
  // Widened sums so a full counter cannot wrap
  assign err_limit        = err_hit &&
                            ({1'b0, err_cnt_reg} + 5'h01 >= {1'b0, frame_error_tolerance});
  assign win_end          = ({1'b0, win_cnt_reg} + 5'h01 >= {1'b0, frame_error_window});

  always @* begin
    fl_state_next = fl_state_reg;
    win_cnt_next  = win_cnt_reg;
    err_cnt_next  = err_cnt_reg;
    case (fl_state_reg)
      FL_ALIGNED: begin
        if (frame_bit_tick) begin
          // Declare once tolerance errors land inside the window
          if (err_limit) begin
            fl_state_next = FL_LOST;
            win_cnt_next  = 4'h0;
            err_cnt_next  = 4'h0;
          end else if (win_end) begin
            win_cnt_next  = 4'h0;
            err_cnt_next  = 4'h0;
          end else begin
            win_cnt_next  = win_cnt_reg + 4'h1;
            err_cnt_next  = err_cnt_reg + {3'h0, err_hit};
          end
        end
      end
      FL_LOST: begin
        // Counters idle while lost
        win_cnt_next = 4'h0;
        err_cnt_next = 4'h0;
        if (frame_realigned) begin
          fl_state_next = FL_ALIGNED;
        end
      end
      default: begin
        fl_state_next = FL_ALIGNED;
        win_cnt_next  = 4'h0;
        err_cnt_next  = 4'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      fl_state_reg <= FL_ALIGNED;
      win_cnt_reg  <= 4'h0;
      err_cnt_reg  <= 4'h0;
    end else begin
      fl_state_reg <= fl_state_next;
      win_cnt_reg  <= win_cnt_next;
      err_cnt_reg  <= err_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Alarm persistence
  // ----------------------------------------------------------------
  wire                          ais_state;
  wire                          yel_state;

  rae_persist #(
    .CW      (`RAE_CNT_W),
    .SET_CYC (AIS_CYC),
    .CLR_CYC (AIS_CYC)
  ) u_ais (
    .clk       (clk),
    .rstn      (rstn),
    .raw       (all_ones_raw),
    .state_reg (ais_state)
  );

  rae_persist #(
    .CW      (`RAE_CNT_W),
    .SET_CYC (YEL_CYC),
    .CLR_CYC ({`RAE_CNT_W{1'b0}})
  ) u_yel (
    .clk       (clk),
    .rstn      (rstn),
    .raw       (remote_alarm_raw),
    .state_reg (yel_state)
  );

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  reg                           oof_d_reg;
  reg                           ais_d_reg;
  reg                           yel_d_reg;
  wire [3:0]                    evt;

  always @(posedge clk) begin
    if (!rstn) begin
      oof_d_reg <= 1'b0;
      ais_d_reg <= 1'b0;
      yel_d_reg <= 1'b0;
    end else begin
      oof_d_reg <= oof_state;
      ais_d_reg <= ais_state;
      yel_d_reg <= yel_state;
    end
  end

  // Either edge counts as a change
  assign evt[`RAE_BIT_OOF_CHG] = edge_seen(oof_state, oof_d_reg);
  assign evt[`RAE_BIT_AIS_CHG] = edge_seen(ais_state, ais_d_reg);
  assign evt[`RAE_BIT_YEL_CHG] = edge_seen(yel_state, yel_d_reg);
  assign evt[`RAE_BIT_LCV]     = line_code_error;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @* begin
    frm_cfg_next                = frm_cfg_reg;
    irq_enable_next             = irq_enable_reg;
    alarm_block_irq_enable_next = alarm_block_irq_enable_reg;
    if (reg_wr) begin
      if (cfg_sel) begin
        frm_cfg_next = reg_wdata;
      end
      // Upper enable bits are not stored
      if (ena_sel) begin
        irq_enable_next = reg_wdata[3:0];
      end
      if (blk_sel) begin
        alarm_block_irq_enable_next = reg_wdata[`RAE_BIT_ALARM_BLK];
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      frm_cfg_reg                <= `RAE_FRM_CFG_RST;
      irq_enable_reg             <= `RAE_ENABLE_RST;
      alarm_block_irq_enable_reg <= `RAE_BLK_EN_RST;
    end else begin
      frm_cfg_reg                <= frm_cfg_next;
      irq_enable_reg             <= irq_enable_next;
      alarm_block_irq_enable_reg <= alarm_block_irq_enable_next;
    end
  end

  // ----------------------------------------------------------------
  // Sticky status: read or write-one clears, new event wins
  // ----------------------------------------------------------------
  always @* begin
    status_next = status_reg;
    if (reg_rd && hit(reg_addr, `RAE_OFS_STATUS)) begin
      status_next = 4'h0;
    end
    if (reg_wr && hit(reg_addr, `RAE_OFS_STATUS)) begin
      status_next = status_next & ~reg_wdata[3:0];
    end
    status_next = status_next | (evt & `RAE_EVT_MSK);
  end

  always @(posedge clk) begin
    if (!rstn) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, `RAE_OFS_STATUS)) begin
        rdata_next = {oof_state, ais_state, yel_state, loss_of_signal, status_reg};
      end else if (hit(reg_addr, `RAE_OFS_ENABLE)) begin
        rdata_next = {4'h0, irq_enable_reg};
      end else if (hit(reg_addr, `RAE_OFS_BLK_EN)) begin
        rdata_next = {6'h00, alarm_block_irq_enable_reg, 1'b0};
      end else if (hit(reg_addr, `RAE_OFS_FRM_CFG)) begin
        rdata_next = frm_cfg_reg;
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Built from next values so the flop tracks status with no extra cycle
  assign src_irq_next = status_next & irq_enable_next;

  always @(posedge clk) begin
    if (!rstn) begin
      alarm_irq_reg <= 1'b0;
    end else begin
      alarm_irq_reg <= alarm_block_irq_enable_next && (|src_irq_next);
    end
  end

  assign alarm_irq = alarm_irq_reg;

endmodule

// ### pkg/rae_defs.vh
`ifndef RAE_DEFS_VH
`define RAE_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RAE_ADDR_W          16
`define RAE_OFS_FRM_CFG     16'h010b
`define RAE_OFS_BLK_EN      16'h0b01
`define RAE_OFS_STATUS      16'h0b02
`define RAE_OFS_ENABLE      16'h0b03

// ----------------------------------------------------------------
// Status and enable field positions
// ----------------------------------------------------------------
`define RAE_BIT_YEL_CHG     0
`define RAE_BIT_AIS_CHG     1
`define RAE_BIT_OOF_CHG     2
`define RAE_BIT_LCV         3
`define RAE_BIT_LOS_ST      4
`define RAE_BIT_YEL_ST      5
`define RAE_BIT_AIS_ST      6
`define RAE_BIT_OOF_ST      7
`define RAE_BIT_ALARM_BLK   1
`define RAE_EVT_MSK         4'hf

// ----------------------------------------------------------------
// Frame-loss configuration fields and reset values
// ----------------------------------------------------------------
`define RAE_TOL_HI          7
`define RAE_TOL_LO          4
`define RAE_WIN_HI          3
`define RAE_WIN_LO          0
`define RAE_FRM_CFG_RST     8'h2f
`define RAE_ENABLE_RST      4'h0
`define RAE_BLK_EN_RST      1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RAE_CLK_KHZ         25000
`define RAE_AIS_MS          42
`define RAE_YEL_MS          900
`define RAE_CNT_W           25

`endif

// ### rtl/rae_persist.v
`timescale 1ns/100ps
`include "rae_defs.vh"

// ----------------------------------------------------------------
// Persistence filter: state follows raw after it holds long enough
// ----------------------------------------------------------------
module rae_persist #(
  parameter                     CW      = `RAE_CNT_W,
  parameter [CW-1:0]            SET_CYC = 1,
  parameter [CW-1:0]            CLR_CYC = 1
) (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rstn,
  // Condition in, defect out
  input  wire                   raw,
  output reg                    state_reg
);

  reg  [CW-1:0]                 cnt_reg;
  wire [CW-1:0]                 target;

  // Zero target means the change takes effect at once
  assign target = state_reg ? CLR_CYC : SET_CYC;

  always @(posedge clk) begin
    if (!rstn) begin
      state_reg <= 1'b0;
      cnt_reg   <= {CW{1'b0}};
    end else if (raw == state_reg) begin
      cnt_reg   <= {CW{1'b0}};
    end else if (target == {CW{1'b0}} || cnt_reg == target - 1'b1) begin
      state_reg <= raw;
      cnt_reg   <= {CW{1'b0}};
    end else begin
      cnt_reg   <= cnt_reg + 1'b1;
    end
  end

endmodule

// ### tb/rae_irq_chk.sv
`timescale 1ns/100ps
`include "rae_defs.vh"

module rae_irq_chk #(
  parameter [`RAE_CNT_W-1:0] AIS_CYC = 1,
  parameter [`RAE_CNT_W-1:0] YEL_CYC = 1
) (
  // Clock and reset
  input wire                   clk,
  input wire                   rstn,
  // Register port
  input wire [`RAE_ADDR_W-1:0] reg_addr,
  input wire [7:0]             reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [7:0]             reg_rdata,
  // Line side and outputs
  input wire                   frame_bit_tick,
  input wire                   frame_realigned,
  input wire                   line_code_error,
  input wire                   alarm_irq,
  input wire                   frame_loss_state
);
  // ----------------------------------------------------------------
  // Shadow of enables
  // ----------------------------------------------------------------
  reg       blk_q;
  reg [3:0] en_q;
  wire      st_rd = reg_rd && (reg_addr == `RAE_OFS_STATUS);
  always @(posedge clk) begin
    if (!rstn) begin
      blk_q <= 1'b0;
      en_q  <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == `RAE_OFS_BLK_EN) blk_q <= reg_wdata[1];
      if (reg_addr == `RAE_OFS_ENABLE) en_q <= reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_enable_rsvd: assert property ($past(reg_rd && reg_addr == `RAE_OFS_ENABLE)
    |-> reg_rdata[7:4] == 4'h0) else $error("reserved enable bits read nonzero");
  a_oof_change: assert property ($changed(frame_loss_state) ##1 st_rd |=> reg_rdata[2])
    else $error("frame loss change not flagged");
  a_oof_state: assert property (st_rd |=> reg_rdata[7] == $past(frame_loss_state))
    else $error("frame loss state bit wrong");
  a_irq_block: assert property (alarm_irq |-> blk_q)
    else $error("interrupt without block enable");
  a_irq_source: assert property (alarm_irq |-> en_q != 4'h0)
    else $error("interrupt without source enable");
  a_lcv_irq: assert property (line_code_error && blk_q && en_q[3] && !reg_wr |=> alarm_irq)
    else $error("line code error did not interrupt");
  a_lcv_flag: assert property (line_code_error ##1 st_rd |=> reg_rdata[3])
    else $error("line code error not flagged");
  a_irq_hold: assert property (alarm_irq && !reg_rd && !reg_wr |=> alarm_irq)
    else $error("interrupt dropped without access");
  a_realign_clr: assert property (frame_realigned && !frame_bit_tick |=> !frame_loss_state)
    else $error("frame loss not cleared on realign");
  c_lcv_irq: cover property (line_code_error ##1 alarm_irq);
  c_oof_rise: cover property ($rose(frame_loss_state));
  c_irq_fall: cover property ($fell(alarm_irq));
endmodule

bind rae_irq rae_irq_chk #(.AIS_CYC(AIS_CYC), .YEL_CYC(YEL_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_bit_tick(frame_bit_tick),
  .frame_realigned(frame_realigned), .line_code_error(line_code_error),
  .alarm_irq(alarm_irq), .frame_loss_state(frame_loss_state));

// ### tb/tb_top.sv
`timescale 1ns/100ps
`include "rae_defs.vh"

module tb_top;
  localparam int    AIS_N = 20;
  localparam int    YEL_N = 50;
  localparam [15:0] ST    = `RAE_OFS_STATUS;
  localparam [15:0] EN    = `RAE_OFS_ENABLE;
  reg        clk, rstn, reg_wr, reg_rd, frame_bit_tick, frame_bit_err, frame_realigned;
  reg        all_ones_raw, remote_alarm_raw, loss_of_signal, line_code_error;
  reg [15:0] reg_addr;
  reg [7:0]  reg_wdata;
  wire [7:0] reg_rdata;
  wire       alarm_irq, frame_loss_state;
  integer    failures, n_compared;
  rae_irq #(.AIS_CYC(AIS_N), .YEL_CYC(YEL_N)) u_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_bit_tick(frame_bit_tick),
    .frame_bit_err(frame_bit_err), .frame_realigned(frame_realigned),
    .all_ones_raw(all_ones_raw), .remote_alarm_raw(remote_alarm_raw),
    .loss_of_signal(loss_of_signal), .line_code_error(line_code_error),
    .alarm_irq(alarm_irq), .frame_loss_state(frame_loss_state));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task wait_cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rdchk(input [15:0] a, input [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata, exp);
  endtask
  task pulse_lcv;
    @(posedge clk);
    line_code_error <= 1'b1;
    @(posedge clk);
    line_code_error <= 1'b0;
    #1;
  endtask
  task tick_fb(input e);
    @(posedge clk);
    frame_bit_tick <= 1'b1;
    frame_bit_err <= e;
    @(posedge clk);
    frame_bit_tick <= 1'b0;
    frame_bit_err <= 1'b0;
  endtask
  task wrap_up;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, frame_bit_tick, frame_bit_err, frame_realigned} = 6'h00;
    {all_ones_raw, remote_alarm_raw, loss_of_signal, line_code_error} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    failures = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdchk(ST, 8'h00);
    rdchk(EN, 8'h00);
    rdchk(`RAE_OFS_BLK_EN, 8'h00);
    rdchk(`RAE_OFS_FRM_CFG, 8'h2f);
    rdchk(16'h0b00, 8'h00);
    wr(EN, 8'hef);
    rdchk(EN, 8'h0f);
    wr(EN, 8'h08);
    $display("test registers done");
    pulse_lcv;
    chk8({7'h00, alarm_irq}, 8'h00);
    rdchk(ST, 8'h08);
    rdchk(ST, 8'h00);
    wr(`RAE_OFS_BLK_EN, 8'h02);
    pulse_lcv;
    chk8({7'h00, alarm_irq}, 8'h01);
    wr(ST, 8'h08);
    chk8({7'h00, alarm_irq}, 8'h00);
    wr(EN, 8'h00);
    pulse_lcv;
    chk8({7'h00, alarm_irq}, 8'h00);
    rdchk(ST, 8'h08);
    $display("test line code done");
    wr(EN, 8'h02);
    @(posedge clk);
    all_ones_raw <= 1'b1;
    wait_cyc(AIS_N - 4);
    chk8({7'h00, alarm_irq}, 8'h00);
    wait_cyc(8);
    chk8({7'h00, alarm_irq}, 8'h01);
    rdchk(ST, 8'h42);
    chk8({7'h00, alarm_irq}, 8'h00);
    @(posedge clk);
    all_ones_raw <= 1'b0;
    wait_cyc(AIS_N - 5);
    rdchk(ST, 8'h40);
    wait_cyc(8);
    chk8({7'h00, alarm_irq}, 8'h01);
    rdchk(ST, 8'h02);
    $display("test all ones done");
    wr(EN, 8'h01);
    @(posedge clk);
    remote_alarm_raw <= 1'b1;
    wait_cyc(YEL_N - 5);
    rdchk(ST, 8'h00);
    wait_cyc(8);
    chk8({7'h00, alarm_irq}, 8'h01);
    rdchk(ST, 8'h21);
    @(posedge clk);
    remote_alarm_raw <= 1'b0;
    wait_cyc(3);
    chk8({7'h00, alarm_irq}, 8'h01);
    rdchk(ST, 8'h01);
    $display("test remote alarm done");
    wr(`RAE_OFS_FRM_CFG, 8'h24);
    wr(EN, 8'h04);
    tick_fb(1'b1);
    repeat (3) tick_fb(1'b0);
    wait_cyc(2);
    chk8({7'h00, frame_loss_state}, 8'h00);
    repeat (4) tick_fb(1'b1);
    wait_cyc(2);
    chk8({7'h00, frame_loss_state}, 8'h01);
    chk8({7'h00, alarm_irq}, 8'h01);
    rdchk(ST, 8'h84);
    @(posedge clk);
    frame_realigned <= 1'b1;
    loss_of_signal <= 1'b1;
    @(posedge clk);
    frame_realigned <= 1'b0;
    wait_cyc(2);
    chk8({7'h00, frame_loss_state}, 8'h00);
    chk8({7'h00, alarm_irq}, 8'h01);
    wr(EN, 8'h00);
    chk8({7'h00, alarm_irq}, 8'h00);
    rdchk(ST, 8'h14);
    $display("test frame loss done");
    wr(EN, 8'h08);
    pulse_lcv;
    chk8({7'h00, alarm_irq}, 8'h01);
    @(posedge clk);
    rstn <= 1'b0;
    loss_of_signal <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk8({7'h00, alarm_irq}, 8'h00);
    rdchk(ST, 8'h00);
    rdchk(EN, 8'h00);
    rdchk(`RAE_OFS_FRM_CFG, 8'h2f);
    $display("test reset done");
    wrap_up;
  end
  initial begin
    #400000;
    failures = failures + 1;
    wrap_up;
  end
endmodule
